/* bench/ris_pin_model.sv */
// Pin-side model: drives the remappable pins and comparator one.
// Assumes the bench picks one pin to drive; all others show its inverse.
`timescale 1ns/1ps
module ris_pin_model (
    input wire logic ref_clk,
    input wire logic [7:0] pinIdx,
    input wire logic pinLvl,
    input wire logic cmpLvl,
    output logic comparator_one_out,
    output logic [ris_pkg::NUM_SRC-1:0] remappable_pin
);
    // Others carry the inverse so a wrong pick shows as a wrong level
    always @(posedge ref_clk) begin
        for (int k = 0; k < ris_pkg::NUM_SRC; k++) begin
            remappable_pin[k] <= (k == int'(pinIdx)) ? pinLvl : !pinLvl;
        end
        comparator_one_out <= cmpLvl;
    end
endmodule

/* bench/tb.sv */
// Self-checking bench for the remappable input select block.
// Assumes APB answers with a pready pulse and the pin model above.
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [5:0] paddr = 6'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic comparator_one_out;
    logic [ris_pkg::NUM_SRC-1:0] remappable_pin;
    logic [11:0] routed_inputs;
    logic [7:0] pinIdx = 8'hB5;
    logic pinLvl = 1'b0;
    logic cmpLvl = 1'b0;
    logic [5:0] addrTab [12];
    int lsbTab [12];
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;

    always #20 ref_clk = !ref_clk;

    ris_input_select u_ris_input_select (.ref_clk(ref_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_one_out(comparator_one_out),
        .remappable_pin(remappable_pin), .routed_inputs(routed_inputs));

    ris_pin_model u_ris_pin_model (.ref_clk(ref_clk), .pinIdx(pinIdx),
        .pinLvl(pinLvl), .cmpLvl(cmpLvl),
        .comparator_one_out(comparator_one_out),
        .remappable_pin(remappable_pin));

    // Hang guard: far above the roughly one thousand cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; outputs read at the edge where pready is sampled
    task automatic apb(input logic w, input logic [5:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, 4'hF, rd, err);
    endtask

    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0000_0000);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 12; i++) rdchk(addrTab[i], 32'h0000_0000);
        chk({20'h0, routed_inputs}, 32'h0000_0000);
        $display("test reset done");
    endtask

    // All-ones writes keep only the implemented select bytes
    task automatic t_rw();
        logic [31:0] mask;
        logic [31:0] rd;
        logic err;
        for (int i = 0; i < 12; i++) begin
            mask = 0;
            for (int j = 0; j < 12; j++) begin
                if (addrTab[j] == addrTab[i]) begin
                    mask = mask | (32'h0000_00FF << lsbTab[j]);
                end
            end
            wr(addrTab[i], 32'hFFFF_FFFF);
            rdchk(addrTab[i], mask);
            wr(addrTab[i], 32'h0000_0000);
            rdchk(addrTab[i], 32'h0000_0000);
        end
        apb(1'b1, ris_pkg::OFS_CAP_12, 32'h0000_AAAA, 4'h2, rd, err);
        rdchk(ris_pkg::OFS_CAP_12, 32'h0000_AA00);
        wr(ris_pkg::OFS_CAP_12, 32'h0000_0000);
        $display("test register access done");
    endtask

    task automatic route(input int i, input logic [7:0] code,
                         input logic [11:0] exp);
        wr(addrTab[i], 32'(code) << lsbTab[i]);
        repeat (5) @(posedge ref_clk);
        chk({20'h0, routed_inputs}, {20'h0, exp});
        wr(addrTab[i], 32'h0000_0000);
    endtask

    // Every routed input through pin 181, comparator one and ground
    task automatic t_route();
        // Other pins show the inverse level, so a wrong pick is visible
        for (int i = 0; i < 12; i++) begin
            pinLvl <= 1'b1;
            cmpLvl <= 1'b0;
            route(i, 8'hB5, 12'h001 << i);
            pinLvl <= 1'b0;
            route(i, 8'hB5, 12'h000);
            route(i, 8'h00, 12'h000);
            pinLvl <= 1'b1;
            cmpLvl <= 1'b1;
            route(i, 8'h01, 12'h001 << i);
        end
        $display("test routing done");
    endtask

    task automatic t_unmapped();
        logic [31:0] rd;
        logic err;
        wr(ris_pkg::OFS_SER_TWO, 32'h0000_0042);
        apb(1'b1, 6'h3C, 32'hFFFF_FFFF, 4'hF, rd, err);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 6'h3C, 32'h0000_0000, 4'h0, rd, err);
        chk(rd, 32'h0000_0000);
        rdchk(ris_pkg::OFS_SER_TWO, 32'h0000_0042);
        $display("test unmapped done");
    endtask

    // Reset in mid-run must clear fields that software has written
    task automatic t_rst_mid();
        wr(ris_pkg::OFS_IRQ_ONE, 32'h0000_B500);
        wr(ris_pkg::OFS_PWM_FLT, 32'h0000_0102);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk(ris_pkg::OFS_IRQ_ONE, 32'h0000_0000);
        rdchk(ris_pkg::OFS_PWM_FLT, 32'h0000_0000);
        rdchk(ris_pkg::OFS_SER_TWO, 32'h0000_0000);
        chk({20'h0, routed_inputs}, 32'h0000_0000);
        $display("test mid-run reset done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        addrTab = '{ris_pkg::OFS_IRQ_ONE, ris_pkg::OFS_IRQ_TWO,
            ris_pkg::OFS_TMR_TWO, ris_pkg::OFS_CAP_12, ris_pkg::OFS_CAP_12,
            ris_pkg::OFS_CAP_34, ris_pkg::OFS_CAP_34, ris_pkg::OFS_CMP_FLT,
            ris_pkg::OFS_PWM_FLT, ris_pkg::OFS_PWM_FLT, ris_pkg::OFS_SER_ONE,
            ris_pkg::OFS_SER_TWO};
        lsbTab = '{8, 0, 0, 0, 8, 0, 8, 0, 0, 8, 0, 0};
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_rw();
        t_route();
        t_unmapped();
        t_rst_mid();
        wrap_up();
    end
endmodule

/* hw/ris_input_select.sv */
// Remappable input select: APB-programmed select fields route pins or
// comparator one onto twelve peripheral inputs.
// Assumes APB master on ref_clk; pins and comparator are asynchronous.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

// Summary of operation
// - External interrupt one select lives in bits 15-8; low byte unused.
// - External interrupt two select lives in bits 7-0; high byte unused.
// - Timer two clock select lives in bits 7-0 of its register.
// - Capture one select low byte, capture two select high byte.
// - Capture three select low byte, capture four select high byte.
// - Compare fault A select in bits 7-0; high byte unused.
// - PWM fault one select low byte, fault two select high byte.
// - Serial one receive select in bits 7-0 of its register.
// - Serial two receive select in bits 7-0 of its register.
// - Code zero ties the routed input low.
// - Code one routes comparator one output.
// - Code 0xB5 routes remappable input pin 181.
// - Unimplemented bits read as zero.
// - Select bits are read/write and reset to zero.
module ris_input_select (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ris_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_one_out,
    input wire logic [ris_pkg::NUM_SRC-1:0] remappable_pin,
    output logic [ris_pkg::NUM_ROUTES-1:0] routed_inputs
);
    ris_pkg::ris_apb_req_s req;
    logic [ris_pkg::SEL_W-1:0] sel_r [ris_pkg::NUM_ROUTES];
    logic [ris_pkg::SEL_W-1:0] sel_nxt [ris_pkg::NUM_ROUTES];
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [ris_pkg::NUM_SRC-1:0] srcMeta_r;
    logic [ris_pkg::NUM_SRC-1:0] srcSync_r;
    logic [ris_pkg::NUM_SRC-1:0] srcRaw;
    logic access;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata, pstrb: pstrb};

    // Index 0 of the source vector is ground; slot 1 carries comparator one
    always_comb begin
        srcRaw = remappable_pin;
        srcRaw[0] = 1'b0;
        srcRaw[ris_pkg::CODE_COMPARATOR_ONE_OUT] = comparator_one_out;
    end

    // Two-flop synchroniser for every asynchronous source
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            srcMeta_r <= '0;
            srcSync_r <= '0;
        end else begin
            srcMeta_r <= srcRaw;
            srcSync_r <= srcMeta_r;
        end
    end

    // Map an address to its register: is it known at all
    function automatic logic addr_known(input logic [ris_pkg::ADDR_W-1:0] a);
        unique case (a)
            ris_pkg::OFS_IRQ_ONE, ris_pkg::OFS_IRQ_TWO, ris_pkg::OFS_TMR_TWO,
            ris_pkg::OFS_CAP_12, ris_pkg::OFS_CAP_34, ris_pkg::OFS_CMP_FLT,
            ris_pkg::OFS_PWM_FLT, ris_pkg::OFS_SER_ONE,
            ris_pkg::OFS_SER_TWO: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    // Read image of a register; unused halves are fixed zero
    function automatic logic [31:0] read_word(
        input logic [ris_pkg::ADDR_W-1:0] a,
        input logic [ris_pkg::SEL_W-1:0] s [ris_pkg::NUM_ROUTES]);
        logic [31:0] w;
        w = ris_pkg::RD_ZERO;
        unique case (a)
            ris_pkg::OFS_IRQ_ONE: begin
                w[ris_pkg::HI_LSB +: 8] = s[ris_pkg::IDX_IRQ_ONE];
            end
            ris_pkg::OFS_IRQ_TWO: begin
                w[ris_pkg::LO_LSB +: 8] = s[ris_pkg::IDX_IRQ_TWO];
            end
            ris_pkg::OFS_TMR_TWO: begin
                w[ris_pkg::LO_LSB +: 8] = s[ris_pkg::IDX_TMR_TWO];
            end
            ris_pkg::OFS_CAP_12: begin
                w[ris_pkg::LO_LSB +: 8] = s[ris_pkg::IDX_CAP_ONE];
                w[ris_pkg::HI_LSB +: 8] = s[ris_pkg::IDX_CAP_TWO];
            end
            ris_pkg::OFS_CAP_34: begin
                w[ris_pkg::LO_LSB +: 8] = s[ris_pkg::IDX_CAP_THREE];
                w[ris_pkg::HI_LSB +: 8] = s[ris_pkg::IDX_CAP_FOUR];
            end
            ris_pkg::OFS_CMP_FLT: begin
                w[ris_pkg::LO_LSB +: 8] = s[ris_pkg::IDX_CMP_FLT];
            end
            ris_pkg::OFS_PWM_FLT: begin
                w[ris_pkg::LO_LSB +: 8] = s[ris_pkg::IDX_PWM_ONE];
                w[ris_pkg::HI_LSB +: 8] = s[ris_pkg::IDX_PWM_TWO];
            end
            ris_pkg::OFS_SER_ONE: begin
                w[ris_pkg::LO_LSB +: 8] = s[ris_pkg::IDX_SER_ONE];
            end
            ris_pkg::OFS_SER_TWO: begin
                w[ris_pkg::LO_LSB +: 8] = s[ris_pkg::IDX_SER_TWO];
            end
            default: w = ris_pkg::RD_ZERO;
        endcase
        return w;
    endfunction

    assign access = req.psel && req.penable && !pready_r;

    // Write decode: each field takes its byte lane only when strobed;
    // bytes with no field behind them are simply dropped
    always_comb begin
        for (int i = 0; i < ris_pkg::NUM_ROUTES; i++) begin
            sel_nxt[i] = sel_r[i];
        end
        if (access && req.pwrite) begin
            unique case (req.paddr)
                ris_pkg::OFS_IRQ_ONE: begin
                    if (req.pstrb[1]) begin
                        sel_nxt[ris_pkg::IDX_IRQ_ONE] =
                            req.pwdata[ris_pkg::HI_LSB +: 8];
                    end
                end
                ris_pkg::OFS_IRQ_TWO: begin
                    if (req.pstrb[0]) begin
                        sel_nxt[ris_pkg::IDX_IRQ_TWO] =
                            req.pwdata[ris_pkg::LO_LSB +: 8];
                    end
                end
                ris_pkg::OFS_TMR_TWO: begin
                    if (req.pstrb[0]) begin
                        sel_nxt[ris_pkg::IDX_TMR_TWO] =
                            req.pwdata[ris_pkg::LO_LSB +: 8];
                    end
                end
                ris_pkg::OFS_CAP_12: begin
                    if (req.pstrb[0]) begin
                        sel_nxt[ris_pkg::IDX_CAP_ONE] =
                            req.pwdata[ris_pkg::LO_LSB +: 8];
                    end
                    if (req.pstrb[1]) begin
                        sel_nxt[ris_pkg::IDX_CAP_TWO] =
                            req.pwdata[ris_pkg::HI_LSB +: 8];
                    end
                end
                ris_pkg::OFS_CAP_34: begin
                    if (req.pstrb[0]) begin
                        sel_nxt[ris_pkg::IDX_CAP_THREE] =
                            req.pwdata[ris_pkg::LO_LSB +: 8];
                    end
                    if (req.pstrb[1]) begin
                        sel_nxt[ris_pkg::IDX_CAP_FOUR] =
                            req.pwdata[ris_pkg::HI_LSB +: 8];
                    end
                end
                ris_pkg::OFS_CMP_FLT: begin
                    if (req.pstrb[0]) begin
                        sel_nxt[ris_pkg::IDX_CMP_FLT] =
                            req.pwdata[ris_pkg::LO_LSB +: 8];
                    end
                end
                ris_pkg::OFS_PWM_FLT: begin
                    if (req.pstrb[0]) begin
                        sel_nxt[ris_pkg::IDX_PWM_ONE] =
                            req.pwdata[ris_pkg::LO_LSB +: 8];
                    end
                    if (req.pstrb[1]) begin
                        sel_nxt[ris_pkg::IDX_PWM_TWO] =
                            req.pwdata[ris_pkg::HI_LSB +: 8];
                    end
                end
                ris_pkg::OFS_SER_ONE: begin
                    if (req.pstrb[0]) begin
                        sel_nxt[ris_pkg::IDX_SER_ONE] =
                            req.pwdata[ris_pkg::LO_LSB +: 8];
                    end
                end
                ris_pkg::OFS_SER_TWO: begin
                    if (req.pstrb[0]) begin
                        sel_nxt[ris_pkg::IDX_SER_TWO] =
                            req.pwdata[ris_pkg::LO_LSB +: 8];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Select fields; all start at the ground code
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < ris_pkg::NUM_ROUTES; i++) begin
            if (rst) begin
                sel_r[i] <= ris_pkg::SEL_RST;
            end else begin
                sel_r[i] <= sel_nxt[i];
            end
        end
    end

    // Bus answer: one wait state, so every access ends on its second
    // access-phase edge; unmapped addresses error and read zero
    always_comb begin
        pready_nxt = access;
        pslverr_nxt = access && !addr_known(req.paddr);
        prdata_nxt = ris_pkg::RD_ZERO;
        if (access && !req.pwrite) begin
            prdata_nxt = read_word(req.paddr, sel_r);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= ris_pkg::RD_ZERO;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

    // One multiplexer per routed peripheral input
    for (genvar g = 0; g < ris_pkg::NUM_ROUTES; g++) begin : gen_route
        ris_source_mux u_mux (
            .ref_clk(ref_clk),
            .rst(rst),
            .sel(sel_r[g]),
            .sources(srcSync_r),
            .routed(routed_inputs[g])
        );
    end

    // Reset and register-image checks; reset is checked one edge later
    // so the very first edge of the run needs no history
    AST_RESET_GND: assert property (
        @(posedge ref_clk)
        rst |=> sel_r[ris_pkg::IDX_IRQ_ONE] == ris_pkg::SEL_RST
            && sel_r[ris_pkg::IDX_SER_TWO] == ris_pkg::SEL_RST)
        else $error("select not cleared by reset");
    AST_IRQ_ONE_LOW_ZERO: assert property (
        @(posedge ref_clk) disable iff (rst)
        pready && !pwrite && $past(paddr) == ris_pkg::OFS_IRQ_ONE
        |-> prdata[7:0] == 8'h00)
        else $error("unused low byte read nonzero");
    AST_UPPER_ZERO: assert property (
        @(posedge ref_clk) disable iff (rst)
        pready |-> prdata[31:16] == 16'h0000)
        else $error("upper half read nonzero");
    AST_UNUSED_HIGH_ZERO: assert property (
        @(posedge ref_clk) disable iff (rst)
        pready && !pwrite && $past(paddr) == ris_pkg::OFS_SER_ONE
        |-> prdata[15:8] == 8'h00)
        else $error("unused high byte read nonzero");
    AST_CAP_WRITE: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && paddr == ris_pkg::OFS_CAP_12 && pstrb[1]
        |=> sel_r[ris_pkg::IDX_CAP_TWO] == $past(pwdata[15:8]))
        else $error("capture two select not written");
    AST_SER_ONE_WRITE: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && paddr == ris_pkg::OFS_SER_ONE && pstrb[0]
        |=> sel_r[ris_pkg::IDX_SER_ONE] == $past(pwdata[7:0]))
        else $error("serial one select not written");
    AST_IRQ_TWO_HOLD: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && paddr == ris_pkg::OFS_IRQ_ONE
        |=> $stable(sel_r[ris_pkg::IDX_IRQ_TWO]))
        else $error("write leaked into another field");
endmodule

/* hw/ris_source_mux.sv */
// One routing multiplexer: picks ground, comparator one or a remappable
// pin by an 8-bit code and registers the result.
// Assumes the source vector is already synchronised to ref_clk.
`timescale 1ns/1ps
module ris_source_mux (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ris_pkg::SEL_W-1:0] sel,
    input wire logic [ris_pkg::NUM_SRC-1:0] sources,
    output logic routed
);
    logic routed_r;
    logic routed_nxt;

    // Code zero is ground; codes past the last source also read low
    always_comb begin
        if (sel == ris_pkg::CODE_GND) begin
            routed_nxt = 1'b0;
        end else if (sel == ris_pkg::CODE_COMPARATOR_ONE_OUT) begin
            routed_nxt = sources[ris_pkg::CODE_COMPARATOR_ONE_OUT];
        end else if (sel <= ris_pkg::CODE_MAX) begin
            routed_nxt = sources[sel];
        end else begin
            routed_nxt = 1'b0;
        end
    end

    // Registered so the peripheral sees a glitch-free level
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            routed_r <= 1'b0;
        end else begin
            routed_r <= routed_nxt;
        end
    end

    assign routed = routed_r;

    AST_GND_LOW: assert property (
        @(posedge ref_clk) disable iff (rst)
        sel == ris_pkg::CODE_GND |=> !routed)
        else $error("ground code did not give low");
    AST_CMP_PASS: assert property (
        @(posedge ref_clk) disable iff (rst)
        sel == ris_pkg::CODE_COMPARATOR_ONE_OUT |=> routed == $past(sources[1]))
        else $error("comparator one not routed");
    AST_TOP_PIN: assert property (
        @(posedge ref_clk) disable iff (rst)
        sel == ris_pkg::CODE_MAX |=> routed == $past(sources[181]))
        else $error("pin 181 not routed");
endmodule

/* include/ris_pkg.sv */
// Package for the remappable input select block: register map, field
// layout, reset values and source codes.
// Assumes a 32-bit APB slave with one aligned word per register.
package ris_pkg;

    localparam int SEL_W = 8;
    localparam int ADDR_W = 6;
    localparam int NUM_ROUTES = 12;

    // Byte offsets of the select registers
    localparam logic [ADDR_W-1:0] OFS_IRQ_ONE = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_TWO = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_TMR_TWO = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_CAP_12 = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_CAP_34 = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_CMP_FLT = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_PWM_FLT = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_SER_ONE = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_SER_TWO = 6'h20;

    // Field positions inside a 16-bit select register
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 8;

    // Reset value of every select field and register word
    localparam logic [SEL_W-1:0] SEL_RST = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // Source codes
    localparam logic [SEL_W-1:0] CODE_GND = 8'h00;
    localparam logic [SEL_W-1:0] CODE_COMPARATOR_ONE_OUT = 8'h01;
    localparam logic [SEL_W-1:0] CODE_MAX = 8'hB5;
    localparam int NUM_SRC = 182;

    // Index of each routed input in the select array and output bus
    localparam int IDX_IRQ_ONE = 0;
    localparam int IDX_IRQ_TWO = 1;
    localparam int IDX_TMR_TWO = 2;
    localparam int IDX_CAP_ONE = 3;
    localparam int IDX_CAP_TWO = 4;
    localparam int IDX_CAP_THREE = 5;
    localparam int IDX_CAP_FOUR = 6;
    localparam int IDX_CMP_FLT = 7;
    localparam int IDX_PWM_ONE = 8;
    localparam int IDX_PWM_TWO = 9;
    localparam int IDX_SER_ONE = 10;
    localparam int IDX_SER_TWO = 11;

    // APB request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } ris_apb_req_s;

endpackage
